// ===== dv/ucc_assertions.sv
// checker: field decode and register port timing
// assumes binding onto the channel control block, one clock
`timescale 1ns/100ps
module ucc_chk (
  input wire        CLK_IN, RST_IN, WR_IN, RD_IN,
  input wire [7:0]  ADDR_IN,
  input wire [15:0] WDATA_IN, RDATA_OUT,
  input wire        RADIO_CHANNEL_SELECT_OUT, DELIM_LONG_OUT,
  input wire        DELIM_VENDOR_OUT, TX_CODE_VALID_OUT, RX_CODE_VALID_OUT,
  input wire [3:0]  CHANNEL_NUMBER_OUT,
  input wire [1:0]  DELIMITER_KIND_OUT, TX_PRF_OUT, RX_PRF_OUT,
  input wire [4:0]  TX_PREAMBLE_CODE_OUT, RX_PREAMBLE_CODE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  function automatic [2:0] dec(input [4:0] c);
    dec = {c != 0 && c <= 29, c == 0 || c > 24 ? 2'h0 : c > 8 ? 2'h2 : 2'h1};
  endfunction
  wire       w = WR_IN && ADDR_IN == 8'h14;
  wire [1:0] k = DELIMITER_KIND_OUT;
  property p_chan;
    CHANNEL_NUMBER_OUT == (RADIO_CHANNEL_SELECT_OUT ? 4'h9 : 4'h5);
  endproperty
  a_chan: assert property (p_chan) else $error("channel number");
  property p_wchan;
    w |-> ##2 RADIO_CHANNEL_SELECT_OUT == $past(WDATA_IN[0], 2);
  endproperty
  a_wchan: assert property (p_wchan) else $error("channel bit");
  property p_delim;
    {DELIM_LONG_OUT, DELIM_VENDOR_OUT} == {k == 2, k == 1 || k == 2};
  endproperty
  a_delim: assert property (p_delim) else $error("delim");
  property p_tx; w |-> ##2 TX_PREAMBLE_CODE_OUT == $past(WDATA_IN[7:3], 2);
  endproperty
  a_tx: assert property (p_tx) else $error("tx code");
  property p_rx; w |-> ##2 RX_PREAMBLE_CODE_OUT == $past(WDATA_IN[12:8], 2);
  endproperty
  a_rx: assert property (p_rx) else $error("rx code");
  property p_txd; {TX_CODE_VALID_OUT, TX_PRF_OUT} == dec(TX_PREAMBLE_CODE_OUT);
  endproperty
  a_txd: assert property (p_txd) else $error("tx prf");
  property p_rxd; {RX_CODE_VALID_OUT, RX_PRF_OUT} == dec(RX_PREAMBLE_CODE_OUT);
  endproperty
  a_rxd: assert property (p_rxd) else $error("rx prf");
  property p_rsv; RD_IN |=> RDATA_OUT[15:13] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  c_wr: cover property (w && WDATA_IN[0]);
  c_rd: cover property (RD_IN);
  c_long: cover property (DELIM_LONG_OUT);
endmodule
bind ucc_channel_control ucc_chk u_chk (.*);

// ===== dv/uwb_channel_control_reg_bench.sv
// bench: register port stimulus with field and read-back checks
// assumes the channel control block with its bound checker
`timescale 1ns/100ps
module uwb_channel_control_reg_bench;
  logic        clk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0]  a = 8'h00;
  logic [15:0] wd = 16'h0000;
  wire  [15:0] q;
  wire         dl, dv, tv, rv;
  wire  [3:0]  ch;
  wire         rs;
  wire  [4:0]  tc, rc;
  wire  [1:0]  dk, tp, rp;
  int          err_total = 0, num_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  ucc_channel_control u_dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(a),
    .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(q),
    .RADIO_CHANNEL_SELECT_OUT(rs), .CHANNEL_NUMBER_OUT(ch),
    .DELIMITER_KIND_OUT(dk), .DELIM_LONG_OUT(dl), .DELIM_VENDOR_OUT(dv),
    .TX_PREAMBLE_CODE_OUT(tc), .TX_CODE_VALID_OUT(tv), .TX_PRF_OUT(tp),
    .RX_PREAMBLE_CODE_OUT(rc), .RX_CODE_VALID_OUT(rv), .RX_PRF_OUT(rp));
  task chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task summarize;
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // fields settle two edges after the write edge
  task wrt(input [7:0] ad, input [15:0] d);
    @(posedge clk) {wr, a, wd} <= {1'b1, ad, d};
    @(posedge clk) wr <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task rdc(input [7:0] ad, input [15:0] e);
    @(posedge clk) {rd, a} <= {1'b1, ad};
    @(posedge clk) rd <= 0;
    #1 chk(q, e);
  endtask
  function automatic [2:0] dec(input [4:0] c);
    dec = {c != 0 && c <= 29, c == 0 || c > 24 ? 2'h0 : c > 8 ? 2'h2 : 2'h1};
  endfunction
  task t_reset;
    rdc(8'h14, 16'h0006);
    chk({dk, ch}, 6'h35);
  endtask
  task t_delim;
    for (int k = 0; k < 4; k++) begin
      wrt(8'h14, 16'(k << 1));
      chk({dk, dl, dv}, {k[1:0], k==2, k==1 || k==2});
    end
  endtask
  // reserved bits written as ones; rx code runs opposite to tx code
  // the sweep walks all 32 tx codes and toggles the channel bit with the code's low bit
  task t_codes;
    logic [15:0] d;
    for (int c = 0; c < 32; c++) begin
      d = {3'h7, 5'(31 - c), 5'(c), 2'h1, c[0]};
      wrt(8'h14, d);
      chk({tv, tp, rv, rp}, {dec(5'(c)), dec(5'(31 - c))});
      chk(ch, c[0] ? 4'h9 : 4'h5);
      chk({rs, tc, rc}, {c[0], 5'(c), 5'(31 - c)});
      rdc(8'h14, d & 16'h1FFF);
    end
  endtask
  task t_unmap;
    wrt(8'h10, 16'hFFFF);
    rdc(8'h10, 16'h0000);
    rdc(8'h14, 16'h00FB);
  endtask
  always @(posedge clk) if (++cyc == 3000) begin
    err_total++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_reset;
    t_delim;
    t_codes;
    t_unmap;
    summarize;
  end
endmodule

// ===== logic/ucc_channel_control.v
// channel control register: channel, delimiter kind, preamble codes
// assumes a single-cycle strobe register port on the same clock
`timescale 1ns/100ps
`include "ucc_defs.vh"

module ucc_channel_control (
  // clock and reset
  input  wire        CLK_IN,
  input  wire        RST_IN,
  // register port
  input  wire [7:0]  ADDR_IN,
  input  wire [15:0] WDATA_IN,
  input  wire        WR_IN,
  input  wire        RD_IN,
  output reg  [15:0] RDATA_OUT,
  // radio channel
  output reg         RADIO_CHANNEL_SELECT_OUT,
  output reg  [3:0]  CHANNEL_NUMBER_OUT,
  // delimiter
  output reg  [1:0]  DELIMITER_KIND_OUT,
  output reg         DELIM_LONG_OUT,
  output reg         DELIM_VENDOR_OUT,
  // transmit preamble
  output reg  [4:0]  TX_PREAMBLE_CODE_OUT,
  output reg         TX_CODE_VALID_OUT,
  output reg  [1:0]  TX_PRF_OUT,
  // receive preamble
  output reg  [4:0]  RX_PREAMBLE_CODE_OUT,
  output reg         RX_CODE_VALID_OUT,
  output reg  [1:0]  RX_PRF_OUT
);

  reg  [15:0] channel_control;
  wire [15:0] next_channel_control;
  wire        hit;
  wire [4:0]  tx_code;
  wire [4:0]  rx_code;
  wire [1:0]  delim;
  wire        tx_valid;
  wire        rx_valid;
  wire [1:0]  tx_prf;
  wire [1:0]  rx_prf;
  wire [9:0]  codes;
  wire [1:0]  valids;
  wire [3:0]  prfs;

  assign hit = (ADDR_IN == `UCC_CHAN_OFFSET);
  // reserved bits are masked on write so they always read zero
  assign next_channel_control = (WR_IN && hit) ?
    (WDATA_IN & `UCC_WRITE_MASK) : channel_control;
  assign tx_code = channel_control[`UCC_TXCODE_HI:`UCC_TXCODE_LO];
  assign rx_code = channel_control[`UCC_RXCODE_HI:`UCC_RXCODE_LO];
  assign delim   = channel_control[`UCC_DELIM_HI:`UCC_DELIM_LO];

  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      channel_control <= `UCC_RESET_VALUE;
    end else begin
      channel_control <= next_channel_control;
    end
  end

  // unmapped addresses read zero
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (RD_IN && hit) begin
      RDATA_OUT <= channel_control & `UCC_WRITE_MASK;
    end else begin
      RDATA_OUT <= 16'h0000;
    end
  end

  // one decoder per direction: index 0 transmit, index 1 receive
  assign codes = {rx_code, tx_code};
  genvar dir;
  generate
    for (dir = 0; dir < 2; dir = dir + 1) begin : g_dec
      ucc_code_decode u_decode (
        .code_in   (codes[dir*5 +: 5]),
        .valid_out (valids[dir]),
        .prf_out   (prfs[dir*2 +: 2])
      );
    end
  endgenerate
  assign tx_valid = valids[0];
  assign rx_valid = valids[1];
  assign tx_prf   = prfs[1:0];
  assign rx_prf   = prfs[3:2];

  // outputs lag the register by one cycle to stay flop-driven
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RADIO_CHANNEL_SELECT_OUT <= 1'b0;
      CHANNEL_NUMBER_OUT       <= `UCC_CHAN_5;
      DELIMITER_KIND_OUT       <= `UCC_DELIM_STD;
      DELIM_LONG_OUT           <= 1'b0;
      DELIM_VENDOR_OUT         <= 1'b0;
      TX_PREAMBLE_CODE_OUT     <= 5'h00;
      TX_CODE_VALID_OUT        <= 1'b0;
      TX_PRF_OUT               <= `UCC_PRF_NONE;
      RX_PREAMBLE_CODE_OUT     <= 5'h00;
      RX_CODE_VALID_OUT        <= 1'b0;
      RX_PRF_OUT               <= `UCC_PRF_NONE;
    end else begin
      RADIO_CHANNEL_SELECT_OUT <= channel_control[`UCC_CHAN_BIT];
      CHANNEL_NUMBER_OUT <= channel_control[`UCC_CHAN_BIT] ?
        `UCC_CHAN_9 : `UCC_CHAN_5;
      DELIMITER_KIND_OUT <= delim;
      DELIM_LONG_OUT     <= (delim == `UCC_DELIM_V16);
      DELIM_VENDOR_OUT   <= (delim == `UCC_DELIM_V8) ||
                            (delim == `UCC_DELIM_V16);
      TX_PREAMBLE_CODE_OUT <= tx_code;
      TX_CODE_VALID_OUT    <= tx_valid;
      TX_PRF_OUT           <= tx_prf;
      RX_PREAMBLE_CODE_OUT <= rx_code;
      RX_CODE_VALID_OUT    <= rx_valid;
      RX_PRF_OUT           <= rx_prf;
    end
  end

endmodule

// ===== logic/ucc_code_decode.v
// decodes one preamble code into validity and pulse repetition frequency
// assumes a registered code from the same clock; purely combinational
`timescale 1ns/100ps
`include "ucc_defs.vh"

module ucc_code_decode (
  // code in
  input  wire [4:0] code_in,
  // decoded
  output reg        valid_out,
  output reg  [1:0] prf_out
);
  always @* begin
    valid_out = (code_in >= `UCC_CODE_MIN) &&
                (code_in <= `UCC_CODE_MAX);
    // codes 25 to 29 are valid but carry no prf here; left as none
    if (code_in >= `UCC_CODE_MIN && code_in <= `UCC_PRF16_MAX) begin
      prf_out = `UCC_PRF_16;
    end else if (code_in > `UCC_PRF16_MAX &&
                 code_in <= `UCC_PRF64_MAX) begin
      prf_out = `UCC_PRF_64;
    end else begin
      prf_out = `UCC_PRF_NONE;
    end
  end
endmodule

// ===== logic/ucc_defs.vh
// constants for the channel control register block
// assumes a plain strobe-based register port and one 20 MHz clock
//
// Behaviour
// - bit 0 picks channel, zero channel 5, one channel 9, both directions.
// - delimiter kind 00 standard short 8-symbol, 11 the 15.4z 8-symbol.
// - delimiter kind 01 vendor 8-symbol, 10 vendor 16-symbol.
// - transmit preamble code in bits 7 to 3, valid 1 to 29.
// - receive preamble code in bits 12 to 8, valid 1 to 29.
// - codes 1 to 8 give 16 MHz prf, 9 to 24 give 64 MHz.
// - bits 15 to 13 are reserved with no function.
`ifndef UCC_DEFS_VH
`define UCC_DEFS_VH

`define UCC_ADDR_W        8
`define UCC_DATA_W        16
`define UCC_CHAN_OFFSET   8'h14
`define UCC_RESET_VALUE   16'h0006
`define UCC_WRITE_MASK    16'h1FFF
`define UCC_CHAN_BIT      0
`define UCC_DELIM_HI      2
`define UCC_DELIM_LO      1
`define UCC_TXCODE_HI     7
`define UCC_TXCODE_LO     3
`define UCC_RXCODE_HI     12
`define UCC_RXCODE_LO     8
`define UCC_CODE_MIN      5'h01
`define UCC_CODE_MAX      5'h1D
`define UCC_PRF16_MAX     5'h08
`define UCC_PRF64_MAX     5'h18
`define UCC_CHAN_5        4'h5
`define UCC_CHAN_9        4'h9
`define UCC_DELIM_STD     2'h0
`define UCC_DELIM_V8      2'h1
`define UCC_DELIM_V16     2'h2
`define UCC_DELIM_Z8      2'h3
`define UCC_PRF_NONE      2'h0
`define UCC_PRF_16        2'h1
`define UCC_PRF_64        2'h2

`endif
